// >>> include/smmvt_cfg.svh
// constants of the system-management control and vga trap block
// assumes a 32-bit ahb-lite register bus and one 40 MHz core clock
`ifndef SMMVT_CFG_SVH
`define SMMVT_CFG_SVH
// register byte offsets
`define SMMVT_OFF_CTRL 8'h00
`define SMMVT_OFF_BASE 8'h04
`define SMMVT_OFF_SIZE 8'h08
`define SMMVT_OFF_VCTL 8'h0c
`define SMMVT_OFF_VMSK 8'h10
`define SMMVT_OFF_STAT 8'h14
`define SMMVT_OFF_HDR 8'h18
`define SMMVT_OFF_CFG3 8'h1c
// field positions
`define SMMVT_CTRL_FEAT 0
`define SMMVT_CTRL_ACC 1
`define SMMVT_CFG3_NMI 1
`define SMMVT_FLAGS_IF 9
// region size in 4 KB pages, 8192 pages is 32 MB
`define SMMVT_SIZE_MAX 14'h2000
// reset and entry values
`define SMMVT_FLAGS_RST 32'h0000_0002
`define SMMVT_CS_LIMIT 32'hffff_ffff
`define SMMVT_VCTL_RST 6'h00
`define SMMVT_VMSK_RST 32'h0000_0000
// io size codes kept in the header
`define SMMVT_IOSZ_B 8'h01
`define SMMVT_IOSZ_W 8'h03
`define SMMVT_IOSZ_D 8'h0f
`endif

// >>> include/smmvt_pkg.sv
// types of the system-management control and vga trap block
// assumes nothing beyond the cfg header for numbers
package smmvt_pkg;
  // decoded special instruction
  typedef enum logic [3:0] {
    SMMVT_OP_NONE, SMMVT_OP_SAVE_SEG, SMMVT_OP_REST_SEG,
    SMMVT_OP_SAVE_LDT, SMMVT_OP_REST_LDT, SMMVT_OP_SAVE_TSK,
    SMMVT_OP_REST_TSK, SMMVT_OP_ENTRY, SMMVT_OP_RESUME
  } smmvt_op_t;
  // mode of the core
  typedef enum logic [1:0] {
    SMMVT_ST_NORMAL, SMMVT_ST_HW, SMMVT_ST_SW
  } smmvt_state_t;
endpackage

// >>> design/smmvt_decode.sv
// decoder and legality check for the special mode instructions
// assumes the opcode byte after 0F and the modrm reg field are stable
`timescale 1ns/1ps
`include "smmvt_cfg.svh"
module smmvt_decode import smmvt_pkg::*; (
  input wire logic [7:0] opcode,
  input wire logic [2:0] modrm_reg,
  input wire logic [1:0] cur_level,
  input wire logic feat_en,
  input wire logic size_nz,
  input wire logic acc_en,
  input wire logic in_mode,
  output smmvt_op_t kind,
  output logic legal,
  output logic is80
);
  // ===============================================
  // opcode table
  always_comb begin
    case (opcode)
      8'h78: kind = SMMVT_OP_SAVE_SEG;
      8'h79: kind = SMMVT_OP_REST_SEG;
      8'h7a: kind = SMMVT_OP_SAVE_LDT;
      8'h7b: kind = SMMVT_OP_REST_LDT;
      8'h7c: kind = SMMVT_OP_SAVE_TSK;
      8'h7d: kind = SMMVT_OP_REST_TSK;
      8'h38: kind = SMMVT_OP_ENTRY;
      8'haa: kind = SMMVT_OP_RESUME;
      default: kind = SMMVT_OP_NONE;
    endcase
  end
  // ===============================================
  // legality; no check on fetch address, so code outside the region may run them
  wire base_ok = feat_en && size_nz && (cur_level == 2'h0);
  wire seg_ok = (modrm_reg <= 3'h5) && (modrm_reg != 3'h1 || kind == SMMVT_OP_SAVE_SEG);
  wire reg0 = (modrm_reg == 3'h0);
  always_comb begin
    case (kind)
      SMMVT_OP_SAVE_SEG, SMMVT_OP_REST_SEG: legal = base_ok && (acc_en || in_mode) && seg_ok;
      SMMVT_OP_ENTRY: legal = base_ok && acc_en && !in_mode;
      SMMVT_OP_RESUME: legal = base_ok && in_mode;
      SMMVT_OP_NONE: legal = 1'b0;
      default: legal = base_ok && (acc_en || in_mode) && reg0;
    endcase
  end
  // everything but entry and resume moves a full 80-bit image
  assign is80 = (kind != SMMVT_OP_NONE) && (kind != SMMVT_OP_ENTRY) && (kind != SMMVT_OP_RESUME);
endmodule

// >>> design/smmvt_vga_trap.sv
// vga memory-write and port trap detector, registered outputs
// assumes write addresses come from decode and ports from the bus unit
`timescale 1ns/1ps
`include "smmvt_cfg.svh"
module smmvt_vga_trap (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic mem_wr_valid,
  input wire logic [31:0] mem_wr_addr,
  input wire logic io_valid,
  input wire logic [15:0] io_port,
  input wire logic [1:0] io_size,
  input wire logic [5:0] trap_en,
  input wire logic [31:0] win_mask,
  output logic trap,
  output logic trap_mem,
  output logic [7:0] trap_size
);
  localparam logic [31:0] MEM_LO [3] = '{32'h000a_0000, 32'h000b_0000, 32'h000b_8000};
  localparam logic [31:0] MEM_HI [3] = '{32'h000a_ffff, 32'h000b_7fff, 32'h000b_ffff};
  // only write ports feed the memory side, so memory reads can never trap
  logic [2:0] mem_hit;
  logic [2:0] io_hit;
  // ===============================================
  // range compare per window
  genvar i;
  for (i = 0; i < 3; i++) begin : g_rng
    assign mem_hit[i] = mem_wr_valid && trap_en[i] && mem_wr_addr >= MEM_LO[i] && mem_wr_addr <= MEM_HI[i];
    assign io_hit[i] = io_valid && trap_en[3+i] && io_port[15:4] == 12'h03b + 12'(i);
  end
  // mask bit set means that 2 KB block is not displayed; only window 0 sees it
  wire blk_masked = win_mask[mem_wr_addr[15:11]];
  wire mem_trap = (mem_hit[0] && !blk_masked) || mem_hit[1] || mem_hit[2];
  wire io_trap = |io_hit;
  wire [7:0] size_code = (io_size == 2'h0) ? `SMMVT_IOSZ_B : (io_size == 2'h1) ? `SMMVT_IOSZ_W : `SMMVT_IOSZ_D;
  // ===============================================
  // registered trap report
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      trap <= 1'b0;
      trap_mem <= 1'b0;
      trap_size <= 8'h00;
    end else begin
      trap <= mem_trap || io_trap;
      trap_mem <= mem_trap;
      trap_size <= io_trap ? size_code : 8'h00;
    end
  end
endmodule

// >>> design/smmvt_ctrl.sv
// system-management mode control: register slave, mode machine, nmi gate
// assumes an ahb-lite master on hclk and asynchronous pins for smi and nmi
//
// Design decisions made here: the address map and register access over AHB-Lite.
`timescale 1ns/1ps
`include "smmvt_cfg.svh"
module smmvt_ctrl import smmvt_pkg::*; (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic instr_valid,
  input wire logic [7:0] instr_opcode,
  input wire logic [2:0] instr_modrm_reg,
  input wire logic [1:0] current_priv_level,
  input wire logic resume_to_protected,
  input wire logic sys_mgmt_irq_n,
  input wire logic nmi_pin,
  input wire logic mem_wr_valid,
  input wire logic [31:0] mem_wr_addr,
  input wire logic io_valid,
  input wire logic [15:0] io_port,
  input wire logic [1:0] io_size,
  input wire logic [31:0] acc_addr,
  output logic acc_cacheable,
  output logic invalid_opcode,
  output smmvt_op_t op_kind,
  output logic xfer_80bit,
  output logic enter_mode,
  output logic exit_mode,
  output logic system_management_mode,
  output logic regs_to_reset,
  output logic real_mode,
  output logic [31:0] flags_load_val,
  output logic [31:0] cs_base,
  output logic [31:0] cs_limit,
  output logic [31:0] fetch_addr,
  output logic nmi_service,
  output logic hdr_mem_access,
  output logic [7:0] hdr_io_size,
  output logic hdr_sw_entry,
  output logic hdr_vga
);
  // ===============================================
  // register state
  logic feat_en_r, acc_en_r, nmi_en_r;
  logic [19:0] base_r;
  logic [13:0] size_r;
  logic [5:0] vctl_r;
  logic [31:0] vmsk_r;
  logic wr_pend_r;
  logic [7:0] wr_off_r;
  smmvt_state_t state_r, state_nxt;
  logic smi_pend_r, smi_pend_nxt;
  logic nmi_pend_r, nmi_pend_nxt;
  logic smi_q1_r, smi_q2_r, nmi_q1_r, nmi_q2_r, nmi_q3_r;
  smmvt_op_t dec_kind;
  logic dec_legal, dec_is80;
  logic vga_trap, vga_mem;
  logic [7:0] vga_size;

  // register selector, shared by read and write decoding
  function automatic logic [3:0] reg_sel(input logic [7:0] off);
    case (off)
      `SMMVT_OFF_CTRL: reg_sel = 4'h1;
      `SMMVT_OFF_BASE: reg_sel = 4'h2;
      `SMMVT_OFF_SIZE: reg_sel = 4'h3;
      `SMMVT_OFF_VCTL: reg_sel = 4'h4;
      `SMMVT_OFF_VMSK: reg_sel = 4'h5;
      `SMMVT_OFF_STAT: reg_sel = 4'h6;
      `SMMVT_OFF_HDR: reg_sel = 4'h7;
      `SMMVT_OFF_CFG3: reg_sel = 4'h8;
      default: reg_sel = 4'h0;
    endcase
  endfunction

  // ===============================================
  // ahb-lite slave: zero wait states, always okay
  wire addr_ph = hsel && htrans[1] && hready;
  wire [3:0] rd_sel = reg_sel(haddr[7:0]);
  wire [3:0] wr_sel = reg_sel(wr_off_r);
  wire in_mode = (state_r != SMMVT_ST_NORMAL);
  wire [31:0] stat_val = {28'h0, nmi_pend_r, smi_pend_r, state_r};
  wire [31:0] hdr_val = {21'h0, hdr_vga, hdr_sw_entry, hdr_mem_access, hdr_io_size};
  wire [31:0] rd_val =
    (rd_sel == 4'h1) ? {30'h0, acc_en_r, feat_en_r} :
    (rd_sel == 4'h2) ? {base_r, 12'h000} :
    (rd_sel == 4'h3) ? {18'h0, size_r} :
    (rd_sel == 4'h4) ? {26'h0, vctl_r} :
    (rd_sel == 4'h5) ? vmsk_r :
    (rd_sel == 4'h6) ? stat_val :
    (rd_sel == 4'h7) ? hdr_val :
    (rd_sel == 4'h8) ? {30'h0, nmi_en_r, 1'b0} : 32'h0000_0000;
  // sizes above 32 MB are clipped, bits above hwdata[13] are dropped, so the region never exceeds the range
  wire [13:0] size_wr = (hwdata[13:0] > `SMMVT_SIZE_MAX) ? `SMMVT_SIZE_MAX : hwdata[13:0];
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // address phase capture and read data launch
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      wr_off_r <= 8'h00;
      hrdata <= 32'h0000_0000;
    end else begin
      wr_pend_r <= addr_ph && hwrite;
      wr_off_r <= haddr[7:0];
      if (addr_ph && !hwrite) begin
        hrdata <= rd_val;
      end
    end
  end

  // data phase write; unmapped offsets and read-only words drop the data
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      feat_en_r <= 1'b0;
      acc_en_r <= 1'b0;
      nmi_en_r <= 1'b0;
      base_r <= 20'h00000;
      size_r <= 14'h0000;
      vctl_r <= `SMMVT_VCTL_RST;
      vmsk_r <= `SMMVT_VMSK_RST;
    end else if (wr_pend_r) begin
      case (wr_sel)
        4'h1: begin
          feat_en_r <= hwdata[`SMMVT_CTRL_FEAT];
          acc_en_r <= hwdata[`SMMVT_CTRL_ACC];
        end
        4'h2: base_r <= hwdata[31:12];
        4'h3: size_r <= size_wr;
        4'h4: vctl_r <= hwdata[5:0];
        4'h5: vmsk_r <= hwdata;
        4'h8: nmi_en_r <= hwdata[`SMMVT_CFG3_NMI];
        default: ;
      endcase
    end
  end

  // ===============================================
  // cacheability of region accesses; base alignment is left to software
  wire [32:0] reg_lo = {1'b0, base_r, 12'h000};
  wire [32:0] reg_hi = reg_lo + {7'h00, size_r, 12'h000};
  assign acc_cacheable = ({1'b0, acc_addr} >= reg_lo) && ({1'b0, acc_addr} < reg_hi);

  // ===============================================
  // pin synchronisers; the first stage feeds only the second
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      smi_q1_r <= 1'b1;
      smi_q2_r <= 1'b1;
      nmi_q1_r <= 1'b0;
      nmi_q2_r <= 1'b0;
      nmi_q3_r <= 1'b0;
    end else begin
      smi_q1_r <= sys_mgmt_irq_n;
      smi_q2_r <= smi_q1_r;
      nmi_q1_r <= nmi_pin;
      nmi_q2_r <= nmi_q1_r;
      nmi_q3_r <= nmi_q2_r;
    end
  end

  // ===============================================
  // instruction decode and vga trap detection
  smmvt_decode u_dec (
    .opcode(instr_opcode),
    .modrm_reg(instr_modrm_reg),
    .cur_level(current_priv_level),
    .feat_en(feat_en_r),
    .size_nz(size_r != 14'h0000),
    .acc_en(acc_en_r),
    .in_mode(in_mode),
    .kind(dec_kind),
    .legal(dec_legal),
    .is80(dec_is80)
  );

  smmvt_vga_trap u_vga (
    .hclk(hclk),
    .hresetn(hresetn),
    .mem_wr_valid(mem_wr_valid),
    .mem_wr_addr(mem_wr_addr),
    .io_valid(io_valid),
    .io_port(io_port),
    .io_size(io_size),
    .trap_en(vctl_r),
    .win_mask(vmsk_r),
    .trap(vga_trap),
    .trap_mem(vga_mem),
    .trap_size(vga_size)
  );

  // ===============================================
  // mode machine
  wire ext_smi = !smi_q2_r && feat_en_r && (size_r != 14'h0000);
  wire is_special = instr_valid && (dec_kind != SMMVT_OP_NONE);
  wire sw_go = is_special && dec_legal && dec_kind == SMMVT_OP_ENTRY;
  wire resume_go = is_special && dec_legal && dec_kind == SMMVT_OP_RESUME;
  // traps seen while already in the mode are dropped, as nesting is not kept
  wire hw_go = !in_mode && !sw_go && (ext_smi || smi_pend_r || vga_trap);
  wire enter_go = sw_go || hw_go;

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      SMMVT_ST_NORMAL: begin
        if (sw_go) begin
          state_nxt = SMMVT_ST_SW;
        end else if (hw_go) begin
          state_nxt = SMMVT_ST_HW;
        end
      end
      SMMVT_ST_HW, SMMVT_ST_SW: begin
        if (resume_go) begin
          state_nxt = SMMVT_ST_NORMAL;
        end
      end
      default: state_nxt = SMMVT_ST_NORMAL;
    endcase
  end

  // pin smi during a software session is held until resume; set beats clear
  always_comb begin
    smi_pend_nxt = smi_pend_r;
    if (hw_go) begin
      smi_pend_nxt = 1'b0;
    end
    if (ext_smi && (state_r == SMMVT_ST_SW || sw_go)) begin
      smi_pend_nxt = 1'b1;
    end
  end

  // ===============================================
  // nmi gate: one event is latched while in the mode without enable
  wire nmi_ev = nmi_q2_r && !nmi_q3_r;
  wire nmi_allow = !in_mode || nmi_en_r;
  wire nmi_go = nmi_allow && (nmi_ev || nmi_pend_r);
  always_comb begin
    nmi_pend_nxt = nmi_pend_r;
    if (nmi_go) begin
      nmi_pend_nxt = 1'b0;
    end
    if (nmi_ev && !nmi_allow) begin
      nmi_pend_nxt = 1'b1;
    end
  end

  // state and pending flags
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r <= SMMVT_ST_NORMAL;
      smi_pend_r <= 1'b0;
      nmi_pend_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      smi_pend_r <= smi_pend_nxt;
      nmi_pend_r <= nmi_pend_nxt;
    end
  end

  // ===============================================
  // decode results and entry or exit side effects, all registered
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      invalid_opcode <= 1'b0;
      op_kind <= SMMVT_OP_NONE;
      xfer_80bit <= 1'b0;
      enter_mode <= 1'b0;
      exit_mode <= 1'b0;
      regs_to_reset <= 1'b0;
      nmi_service <= 1'b0;
    end else begin
      invalid_opcode <= is_special && !dec_legal;
      op_kind <= is_special ? dec_kind : SMMVT_OP_NONE;
      xfer_80bit <= is_special && dec_legal && dec_is80;
      enter_mode <= enter_go;
      exit_mode <= resume_go;
      regs_to_reset <= enter_go;
      nmi_service <= nmi_go;
    end
  end

  // execution context handed to the core on entry and on resume
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      real_mode <= 1'b1;
      flags_load_val <= `SMMVT_FLAGS_RST;
      cs_base <= 32'h0000_0000;
      cs_limit <= 32'h0000_0000;
      fetch_addr <= 32'h0000_0000;
      hdr_mem_access <= 1'b0;
      hdr_io_size <= 8'h00;
      hdr_sw_entry <= 1'b0;
      hdr_vga <= 1'b0;
    end else if (enter_go) begin
      real_mode <= 1'b1;
      flags_load_val <= `SMMVT_FLAGS_RST;
      cs_base <= {base_r, 12'h000};
      cs_limit <= `SMMVT_CS_LIMIT;
      fetch_addr <= {base_r, 12'h000};
      hdr_sw_entry <= sw_go;
      hdr_vga <= hw_go && vga_trap;
      hdr_mem_access <= hw_go && vga_trap && vga_mem;
      hdr_io_size <= (hw_go && vga_trap) ? vga_size : 8'h00;
    end else if (resume_go) begin
      real_mode <= !resume_to_protected;
    end
  end

  assign system_management_mode = in_mode;

  // ===============================================
  // checks
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  sequence s_seg_cs_restore;
    instr_valid && instr_opcode == 8'h79 && instr_modrm_reg == 3'h1;
  endsequence
  sequence s_entered;
    enter_mode && system_management_mode;
  endsequence

  property p_illegal_off;
    instr_valid && !feat_en_r && dec_kind inside {SMMVT_OP_SAVE_SEG, SMMVT_OP_REST_TSK, SMMVT_OP_RESUME}
      |=> invalid_opcode;
  endproperty
  a_illegal_off: assert property (p_illegal_off) else $error("special op not refused");

  property p_cs_restore;
    s_seg_cs_restore |=> invalid_opcode && !xfer_80bit;
  endproperty
  a_cs_restore: assert property (p_cs_restore) else $error("code segment restore accepted");

  property p_sw_entry;
    sw_go |=> s_entered ##0 hdr_sw_entry ##0 fetch_addr == {base_r, 12'h000};
  endproperty
  a_sw_entry: assert property (p_sw_entry) else $error("software entry wrong");

  property p_entry_ctx;
    s_entered |-> real_mode && regs_to_reset && cs_limit == 32'hffff_ffff && cs_base == fetch_addr;
  endproperty
  a_entry_ctx: assert property (p_entry_ctx) else $error("entry context wrong");

  property p_if_clear;
    enter_mode |-> !flags_load_val[`SMMVT_FLAGS_IF];
  endproperty
  a_if_clear: assert property (p_if_clear) else $error("interrupt flag left set");

  property p_smi_defer;
    state_r == SMMVT_ST_SW && ext_smi && !resume_go |=> smi_pend_r && state_r == SMMVT_ST_SW ##1 !enter_mode;
  endproperty
  a_smi_defer: assert property (p_smi_defer) else $error("pin smi not deferred");

  property p_nmi_hold;
    in_mode && !nmi_en_r && nmi_ev |=> nmi_pend_r && !nmi_service;
  endproperty
  a_nmi_hold: assert property (p_nmi_hold) else $error("nmi not held");

  property p_resume;
    resume_go |=> exit_mode && !system_management_mode && real_mode == !$past(resume_to_protected);
  endproperty
  a_resume: assert property (p_resume) else $error("resume wrong");

  property p_eighty;
    is_special && dec_legal && dec_kind != SMMVT_OP_ENTRY && dec_kind != SMMVT_OP_RESUME |=> xfer_80bit;
  endproperty
  a_eighty: assert property (p_eighty) else $error("80-bit transfer missing");
endmodule

// >>> verification/smmvt_pin_src.sv
// partner model: the external smi pin and nmi pin drivers
// assumes the bench raises and drops requests just after a rising edge
`timescale 1ns/1ps
module smmvt_pin_src (
  input wire logic smi_req,
  input wire logic nmi_req,
  output logic sys_mgmt_irq_n,
  output logic nmi_pin
);
  // ====================
  // pins
  // smi is a level; the board pulls it up whenever nobody asks
  assign sys_mgmt_irq_n = ~smi_req;
  // nmi is taken on its edge, so a request must fall before the next
  assign nmi_pin = nmi_req;
endmodule

// >>> verification/smm_control_vga_trap_tb.sv
// bench for the mode control and vga trap block: hand cases around a table of ops
// assumes the pin source partner and a zero-wait ahb-lite register slave
`timescale 1ns/1ps
`include "smmvt_cfg.svh"
module smm_control_vga_trap_tb import smmvt_pkg::*;;
  typedef struct {logic [7:0] o; logic [2:0] r; logic [1:0] l; logic bad; smmvt_op_t k;} smmvt_row_t;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, instr_valid, resume_to_protected, smi_req, nmi_req;
  logic sys_mgmt_irq_n, nmi_pin, mem_wr_valid, io_valid, acc_cacheable, invalid_opcode, xfer_80bit;
  logic enter_mode, exit_mode, system_management_mode, regs_to_reset, real_mode, nmi_service;
  logic hdr_mem_access, hdr_sw_entry, hdr_vga;
  logic [1:0] htrans, current_priv_level, io_size;
  logic [2:0] hsize, instr_modrm_reg;
  logic [7:0] instr_opcode, hdr_io_size;
  logic [15:0] io_port;
  logic [31:0] haddr, hwdata, hrdata, mem_wr_addr, acc_addr, flags_load_val, cs_base, cs_limit, fetch_addr, rd;
  smmvt_op_t op_kind;
  int err_count, comparisons, i, n, m;
  // ====================
  // ordinary op cases: opcode, reg field, level, refused, decoded kind
  smmvt_row_t rows [13] = '{
    '{8'h78, 3'h0, 2'h0, 1'h0, SMMVT_OP_SAVE_SEG}, '{8'h78, 3'h5, 2'h0, 1'h0, SMMVT_OP_SAVE_SEG},
    '{8'h79, 3'h3, 2'h0, 1'h0, SMMVT_OP_REST_SEG}, '{8'h79, 3'h1, 2'h0, 1'h1, SMMVT_OP_NONE},
    '{8'h78, 3'h6, 2'h0, 1'h1, SMMVT_OP_NONE}, '{8'h7a, 3'h0, 2'h0, 1'h0, SMMVT_OP_SAVE_LDT},
    '{8'h7b, 3'h0, 2'h0, 1'h0, SMMVT_OP_REST_LDT}, '{8'h7b, 3'h2, 2'h0, 1'h1, SMMVT_OP_NONE},
    '{8'h7c, 3'h0, 2'h0, 1'h0, SMMVT_OP_SAVE_TSK}, '{8'h7d, 3'h0, 2'h0, 1'h0, SMMVT_OP_REST_TSK},
    '{8'h7d, 3'h1, 2'h0, 1'h1, SMMVT_OP_NONE}, '{8'h78, 3'h0, 2'h3, 1'h1, SMMVT_OP_NONE},
    '{8'haa, 3'h0, 2'h0, 1'h1, SMMVT_OP_NONE}};
  logic [31:0] ca [3] = '{32'h0002_fffc, 32'h0003_7ffc, 32'h0003_8000};
  // ====================
  // design and partner
  smmvt_ctrl u_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
    .hreadyout, .hresp, .hrdata, .instr_valid, .instr_opcode, .instr_modrm_reg, .current_priv_level,
    .resume_to_protected, .sys_mgmt_irq_n, .nmi_pin, .mem_wr_valid, .mem_wr_addr, .io_valid, .io_port,
    .io_size, .acc_addr, .acc_cacheable, .invalid_opcode, .op_kind, .xfer_80bit, .enter_mode, .exit_mode,
    .system_management_mode, .regs_to_reset, .real_mode, .flags_load_val, .cs_base, .cs_limit, .fetch_addr,
    .nmi_service, .hdr_mem_access, .hdr_io_size, .hdr_sw_entry, .hdr_vga);
  smmvt_pin_src u_pins (.smi_req, .nmi_req, .sys_mgmt_irq_n, .nmi_pin);
  // ====================
  // tasks
  task automatic chk(string nm, logic [31:0] got, logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // one single transfer; read data is taken at the data-phase edge
  task automatic ahb(logic wr, logic [7:0] a, logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    hsize <= 3'h2;
    haddr <= {24'h0, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
    chk("hresp", hresp, 1'b0);
  endtask
  // op answers stand one cycle, so look just after the taking edge
  task automatic op(logic [7:0] o, logic [2:0] r, logic [1:0] l);
    @(posedge hclk);
    instr_valid <= 1'b1;
    instr_opcode <= o;
    instr_modrm_reg <= r;
    current_priv_level <= l;
    @(posedge hclk);
    instr_valid <= 1'b0;
    #1;
  endtask
  // counts entry and nmi pulses over a bounded span
  task automatic watch(int k);
    n = 0;
    m = 0;
    repeat (k) begin
      @(posedge hclk);
      #1;
      if (enter_mode === 1'b1) n++;
      if (nmi_service === 1'b1) m++;
    end
  endtask
  task automatic trap(logic mw, logic [31:0] a, logic [1:0] s, logic e, logic [7:0] sz);
    @(posedge hclk);
    mem_wr_valid <= mw;
    io_valid <= !mw;
    mem_wr_addr <= a;
    io_port <= a[15:0];
    io_size <= s;
    @(posedge hclk);
    mem_wr_valid <= 1'b0;
    io_valid <= 1'b0;
    watch(5);
    chk("trap entry", n, e);
    if (e) begin
      chk("hdr mem", hdr_mem_access, mw);
      if (!mw) chk("hdr size", hdr_io_size, sz);
      chk("hdr vga", hdr_vga, 1'b1);
      op(8'haa, 3'h0, 2'h0);
    end
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // ====================
  // clock and idle levels at time zero
  initial begin
    hclk = 1'b0;
    {hresetn, hsel, hwrite, instr_valid, resume_to_protected, smi_req, nmi_req, mem_wr_valid, io_valid} = '0;
    {htrans, current_priv_level, io_size, hsize, instr_modrm_reg, instr_opcode, io_port} = '0;
    {haddr, hwdata, mem_wr_addr, acc_addr} = '0;
    forever #12.5 hclk = ~hclk;
  end
  // whole run is under three hundred cycles, so twenty thousand means a hang
  initial begin
    #500000;
    err_count++;
    tally_and_finish;
  end
  // ====================
  // main sequence
  initial begin
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    ahb(1'b0, `SMMVT_OFF_CTRL, 32'h0);
    chk("ctrl reset", rd, 32'h0);
    ahb(1'b0, 8'h40, 32'h0);
    chk("unmapped", rd, 32'h0);
    op(8'h78, 3'h0, 2'h0);
    chk("feature off", invalid_opcode, 1'b1);
    ahb(1'b1, `SMMVT_OFF_CTRL, 32'h3);
    op(8'h7a, 3'h0, 2'h0);
    chk("size zero", invalid_opcode, 1'b1);
    ahb(1'b1, `SMMVT_OFF_SIZE, 32'h3000);
    ahb(1'b0, `SMMVT_OFF_SIZE, 32'h0);
    chk("size clip", rd, 32'h2000);
    ahb(1'b1, `SMMVT_OFF_SIZE, 32'h8);
    ahb(1'b1, `SMMVT_OFF_BASE, 32'h0003_0000);
    ahb(1'b1, `SMMVT_OFF_CTRL, 32'h1);
    op(8'h78, 3'h0, 2'h0);
    chk("no access", invalid_opcode, 1'b1);
    op(8'h38, 3'h0, 2'h0);
    chk("entry refused", invalid_opcode, 1'b1);
    ahb(1'b1, `SMMVT_OFF_CTRL, 32'h3);
    for (i = 0; i < 13; i++) begin
      op(rows[i].o, rows[i].r, rows[i].l);
      chk("invalid", invalid_opcode, rows[i].bad);
      chk("xfer80", xfer_80bit, !rows[i].bad);
      if (!rows[i].bad) chk("kind", op_kind, rows[i].k);
    end
    op(8'h38, 3'h0, 2'h0);
    chk("enter", enter_mode & regs_to_reset & system_management_mode & hdr_sw_entry, 1'b1);
    chk("cs base", cs_base, 32'h0003_0000);
    chk("fetch", fetch_addr, 32'h0003_0000);
    chk("cs limit", cs_limit, `SMMVT_CS_LIMIT);
    chk("real", real_mode, 1'b1);
    chk("flags", flags_load_val, `SMMVT_FLAGS_RST);
    for (i = 0; i < 3; i++) begin
      @(posedge hclk);
      acc_addr <= ca[i];
      #1;
      chk("cacheable", acc_cacheable, i == 1);
    end
    ahb(1'b1, `SMMVT_OFF_CTRL, 32'h1);
    op(8'h7c, 3'h0, 2'h0);
    chk("in mode op", xfer_80bit, 1'b1);
    smi_req <= 1'b1;
    watch(8);
    chk("smi held", n, 0);
    op(8'haa, 3'h0, 2'h0);
    chk("exit", exit_mode, 1'b1);
    watch(4);
    smi_req <= 1'b0;
    chk("smi after resume", n, 1);
    nmi_req <= 1'b1;
    watch(6);
    nmi_req <= 1'b0;
    chk("nmi masked", m, 0);
    ahb(1'b1, `SMMVT_OFF_CFG3, 32'h2);
    watch(6);
    chk("nmi latched", m, 1);
    // header asks for a protected-mode return this time
    resume_to_protected <= 1'b1;
    op(8'haa, 3'h0, 2'h0);
    chk("protected", real_mode, 1'b0);
    resume_to_protected <= 1'b0;
    ahb(1'b1, `SMMVT_OFF_VCTL, 32'h3f);
    ahb(1'b1, `SMMVT_OFF_VMSK, 32'h1);
    trap(1'b1, 32'h000a_0000, 2'h0, 1'b0, 8'h0);
    trap(1'b1, 32'h000a_0800, 2'h0, 1'b1, 8'h0);
    trap(1'b1, 32'h000b_0000, 2'h0, 1'b1, 8'h0);
    trap(1'b1, 32'h000b_fffc, 2'h0, 1'b1, 8'h0);
    trap(1'b1, 32'h000c_0000, 2'h0, 1'b0, 8'h0);
    trap(1'b1, 32'h0009_fffc, 2'h0, 1'b0, 8'h0);
    trap(1'b0, 32'h0000_03b0, 2'h0, 1'b1, `SMMVT_IOSZ_B);
    trap(1'b0, 32'h0000_03cf, 2'h1, 1'b1, `SMMVT_IOSZ_W);
    trap(1'b0, 32'h0000_03df, 2'h2, 1'b1, `SMMVT_IOSZ_D);
    trap(1'b0, 32'h0000_03e0, 2'h0, 1'b0, 8'h0);
    trap(1'b0, 32'h0000_03af, 2'h0, 1'b0, 8'h0);
    ahb(1'b1, `SMMVT_OFF_VCTL, 32'h3e);
    ahb(1'b1, `SMMVT_OFF_VMSK, 32'hffff_ffff);
    trap(1'b1, 32'h000a_0800, 2'h0, 1'b0, 8'h0);
    trap(1'b1, 32'h000b_0800, 2'h0, 1'b1, 8'h0);
    ahb(1'b1, `SMMVT_OFF_VCTL, 32'h0);
    trap(1'b0, 32'h0000_03c4, 2'h0, 1'b0, 8'h0);
    // a second reset while in the mode must drop everything
    ahb(1'b1, `SMMVT_OFF_CTRL, 32'h3);
    op(8'h38, 3'h0, 2'h0);
    chk("enter again", system_management_mode, 1'b1);
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    #1;
    chk("reset mode", system_management_mode, 1'b0);
    chk("reset real", real_mode, 1'b1);
    hresetn <= 1'b1;
    ahb(1'b0, `SMMVT_OFF_CTRL, 32'h0);
    chk("ctrl after reset", rd, 32'h0);
    tally_and_finish;
  end
endmodule
